// *** src/adcsra_defs.svh ***
// constants for the serial register access block
`ifndef ADCSRA_DEFS_SVH
`define ADCSRA_DEFS_SVH
`define ADCSRA_WORD_BITS 16
`define ADCSRA_FRAME_BITS 20
`define ADCSRA_SETUP_RESET 16'h0000
`define ADCSRA_LEVEL_RESET 16'h07FF
`define ADCSRA_SEQ_RESET 16'h0000
`define ADCSRA_CMS_RESET 16'h0000
`define ADCSRA_LEVEL_MASK 16'h07FF
`define ADCSRA_F_CHAN_HI 15
`define ADCSRA_F_CHAN_LO 14
`define ADCSRA_F_UPD_HI 13
`define ADCSRA_F_UPD_LO 12
`define ADCSRA_F_PWR_HI 11
`define ADCSRA_F_PWR_LO 10
`define ADCSRA_F_QUEUE 9
`define ADCSRA_F_SPECIAL 8
`define ADCSRA_F_FULLCLK 7
`define ADCSRA_F_PSEUDO 6
`define ADCSRA_F_CHINFO_OFF 5
`define ADCSRA_F_COUNT 4
`define ADCSRA_F_REF_OFF 10
`define ADCSRA_UPD_ENABLE 2'h1
`endif

// *** src/adcsra_pkg.sv ***
// types for the serial register access block
package adcsra_pkg;
  typedef enum logic [3:0] {
    ADCSRA_ACC_CFG0 = 4'h0,
    ADCSRA_ACC_RD_CFG = 4'h1,
    ADCSRA_ACC_WR_L1 = 4'h2,
    ADCSRA_ACC_RD_L1 = 4'h3,
    ADCSRA_ACC_SWRST = 4'h4,
    ADCSRA_ACC_WR_L2 = 4'h5,
    ADCSRA_ACC_RD_L2 = 4'h6,
    ADCSRA_ACC_CFG7 = 4'h7,
    ADCSRA_ACC_CFG8 = 4'h8,
    ADCSRA_ACC_WR_SEQ = 4'h9,
    ADCSRA_ACC_WR_L1B = 4'hA,
    ADCSRA_ACC_RD_SEQ = 4'hB,
    ADCSRA_ACC_WR_CMS = 4'hC,
    ADCSRA_ACC_WR_L2B = 4'hD,
    ADCSRA_ACC_RD_CMS = 4'hE,
    ADCSRA_ACC_CFGF = 4'hF
  } adcsra_access_t;
  typedef enum logic [2:0] {
    ADCSRA_WR_NONE = 3'h0,
    ADCSRA_WR_L1 = 3'h1,
    ADCSRA_WR_L2 = 3'h3,
    ADCSRA_WR_SEQ = 3'h2,
    ADCSRA_WR_CMS = 3'h6
  } adcsra_pend_t;
endpackage

// *** src/adcsra_top.sv ***
// serial register access logic of a dual sampling converter
//
// Overview of operation
// RL1 - pending write loads a reference level register
// RL2 - armed read shifts register, then four zeros
// RL3 - channel info: indicator, register, two zeros
// RL4 - read-back replaces A data, ignores serial input
// RL5 - both reference levels reset to 7FF
// RL6 - 16-bit words sampled falling edge, MSB first
// RL7 - value applies on rising edge after word
// RL8 - other registers need setup then data write
// RL9 - setup write may also arm a read-back
// RL10 - read-back waits until queue read-out done
// RL11 - host spaces accesses by forty cycles
// RL12 - channel select decoded per input mode
// RL13 - update code 01 writes the setup word
// RL14 - power select field drives power state
// RL15 - queue enable with depth from sequencer register
// RL16 - special read and full clock reset cleared
// RL17 - pseudo-differential bit selects input mode
// RL18 - channel info off pads trailing zeros
// RL19 - counter shown only with channel info
// RL20 - setup-only codes, config read, software reset
// RL21 - sequencer and common-select write/read codes
// RL22 - reference power-off bit ten, default set
// RL23 - reserved upper level bits read zero
`timescale 1ns/1ps
`default_nettype none
`include "adcsra_defs.svh"
module adcsra_top
  import adcsra_pkg::*;
#(
  parameter int WORD_BITS = `ADCSRA_WORD_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic read_strobe,
  input wire logic serial_in,
  input wire logic queue_busy,
  input wire logic result_a,
  input wire logic result_b,
  input wire logic output_b_en,
  output logic output_a,
  output logic output_b,
  output logic [1:0] chan_sel,
  output logic pseudo_diff_en,
  output logic [1:0] power_sel,
  output logic queue_en,
  output logic [1:0] depth_sel,
  output logic special_read_en,
  output logic full_clock_en,
  output logic chan_info_off,
  output logic count_en,
  output logic soft_reset,
  output logic ref_power_off_one,
  output logic ref_power_off_two,
  output logic [9:0] level_one,
  output logic [9:0] level_two,
  output logic [15:0] seq_setup,
  output logic [15:0] cm_setup
);

  // ----------------------------------------
  // link side: word capture on falling edge
  // ----------------------------------------
  logic [15:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] word_reg;
  logic word_tgl_reg;
  logic lrst_m_reg;
  logic lrst_reg;

  always_ff @(negedge link_clk) begin
    lrst_m_reg <= rst;
    lrst_reg <= lrst_m_reg;
  end

  always_ff @(negedge link_clk) begin
    if (lrst_reg) begin
      bit_cnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
      word_reg <= 16'h0000;
      word_tgl_reg <= 1'b0;
    end else if (read_strobe) begin
      bit_cnt_reg <= 5'h01;
      shift_reg <= {15'h0000, serial_in};
    end else if (bit_cnt_reg != 5'h00 && bit_cnt_reg < 5'h10) begin
      shift_reg <= {shift_reg[14:0], serial_in}; // RL6
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      if (bit_cnt_reg == 5'h0F) begin
        word_reg <= {shift_reg[14:0], serial_in};
        word_tgl_reg <= ~word_tgl_reg;
      end
    end else begin
      bit_cnt_reg <= 5'h00;
    end
  end

  // ----------------------------------------
  // crossing into the system clock
  // ----------------------------------------
  logic tgl_m_reg;
  logic tgl_s_reg;
  logic tgl_d_reg;
  logic word_evt;

  always_ff @(posedge clk) begin
    if (rst) begin
      tgl_m_reg <= 1'b0;
      tgl_s_reg <= 1'b0;
      tgl_d_reg <= 1'b0;
    end else begin
      tgl_m_reg <= word_tgl_reg;
      tgl_s_reg <= tgl_m_reg;
      tgl_d_reg <= tgl_s_reg;
    end
  end

  assign word_evt = tgl_s_reg ^ tgl_d_reg;

  // ----------------------------------------
  // register file and access decode
  // ----------------------------------------
  logic [15:0] setup_word_reg;
  logic [15:0] reference_level_one_reg;
  logic [15:0] reference_level_two_reg;
  logic [15:0] sequence_queue_setup_reg;
  logic [15:0] reference_common_select_reg;
  adcsra_pend_t pend_reg;
  logic [15:0] rd_val_reg;
  logic rd_arm_reg;
  logic rd_busy;
  logic rb_lvl_reg;
  logic soft_reset_reg;
  adcsra_access_t acc;

  function automatic logic [15:0] level_clean(input logic [15:0] w);
    return w & `ADCSRA_LEVEL_MASK; // RL23
  endfunction

  assign acc = adcsra_access_t'(word_reg[3:0]);

  always_ff @(posedge clk) begin
    if (rst || soft_reset_reg) begin
      setup_word_reg <= `ADCSRA_SETUP_RESET; // RL16
      reference_level_one_reg <= `ADCSRA_LEVEL_RESET; // RL5 RL22
      reference_level_two_reg <= `ADCSRA_LEVEL_RESET; // RL5
      sequence_queue_setup_reg <= `ADCSRA_SEQ_RESET;
      reference_common_select_reg <= `ADCSRA_CMS_RESET;
      pend_reg <= ADCSRA_WR_NONE;
      rd_arm_reg <= 1'b0;
      rd_val_reg <= 16'h0000;
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= 1'b0;
      if (rd_busy) begin
        rd_arm_reg <= 1'b0;
      end
      if (word_evt && !rd_busy && !rb_lvl_reg) begin // RL4
        if (pend_reg != ADCSRA_WR_NONE) begin // RL8
          unique case (pend_reg)
            ADCSRA_WR_L1: reference_level_one_reg <= level_clean(word_reg); // RL1 RL7
            ADCSRA_WR_L2: reference_level_two_reg <= level_clean(word_reg); // RL1
            ADCSRA_WR_SEQ: sequence_queue_setup_reg <= word_reg; // RL21
            ADCSRA_WR_CMS: reference_common_select_reg <= word_reg; // RL21
            default: ;
          endcase
          pend_reg <= ADCSRA_WR_NONE;
        end else if (word_reg[`ADCSRA_F_UPD_HI:`ADCSRA_F_UPD_LO] ==
                     `ADCSRA_UPD_ENABLE) begin // RL13
          setup_word_reg <= word_reg; // RL7 RL9
          unique case (acc) // RL20 RL21
            ADCSRA_ACC_WR_L1, ADCSRA_ACC_WR_L1B: pend_reg <= ADCSRA_WR_L1;
            ADCSRA_ACC_WR_L2, ADCSRA_ACC_WR_L2B: pend_reg <= ADCSRA_WR_L2;
            ADCSRA_ACC_WR_SEQ: pend_reg <= ADCSRA_WR_SEQ;
            ADCSRA_ACC_WR_CMS: pend_reg <= ADCSRA_WR_CMS;
            ADCSRA_ACC_SWRST: soft_reset_reg <= 1'b1;
            ADCSRA_ACC_RD_CFG: begin
              rd_val_reg <= word_reg;
              rd_arm_reg <= 1'b1;
            end
            ADCSRA_ACC_RD_L1: begin
              rd_val_reg <= reference_level_one_reg; // RL2
              rd_arm_reg <= 1'b1;
            end
            ADCSRA_ACC_RD_L2: begin
              rd_val_reg <= reference_level_two_reg; // RL2
              rd_arm_reg <= 1'b1;
            end
            ADCSRA_ACC_RD_SEQ: begin
              rd_val_reg <= sequence_queue_setup_reg;
              rd_arm_reg <= 1'b1;
            end
            ADCSRA_ACC_RD_CMS: begin
              rd_val_reg <= reference_common_select_reg;
              rd_arm_reg <= 1'b1;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // arm handed to link side as a level
  // ----------------------------------------
  logic arm_m_reg;
  logic arm_s_reg;
  logic busy_tgl_reg;
  logic bsy_m_reg;
  logic bsy_s_reg;
  logic bsy_d_reg;
  logic [15:0] rd_hold_reg;
  logic qbusy_m_reg;
  logic qbusy_s_reg;
  logic chinfo_m_reg;
  logic chinfo_s_reg;
  logic chan_m_reg;
  logic chan_s_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      bsy_m_reg <= 1'b0;
      bsy_s_reg <= 1'b0;
      bsy_d_reg <= 1'b0;
    end else begin
      bsy_m_reg <= busy_tgl_reg;
      bsy_s_reg <= bsy_m_reg;
      bsy_d_reg <= bsy_s_reg;
    end
  end

  assign rd_busy = bsy_s_reg ^ bsy_d_reg;

  // ----------------------------------------
  // read-back running, held as a level
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rb_lvl_reg <= 1'b0;
    end else if (rd_busy) begin
      rb_lvl_reg <= ~rb_lvl_reg; // RL4
    end
  end

  always_ff @(negedge link_clk) begin
    arm_m_reg <= rd_arm_reg;
    arm_s_reg <= arm_m_reg;
    qbusy_m_reg <= queue_busy;
    qbusy_s_reg <= qbusy_m_reg;
    chinfo_m_reg <= setup_word_reg[`ADCSRA_F_CHINFO_OFF];
    chinfo_s_reg <= chinfo_m_reg;
    chan_m_reg <= setup_word_reg[`ADCSRA_F_CHAN_HI];
    chan_s_reg <= chan_m_reg;
  end

  // ----------------------------------------
  // output b enable into link domain
  // ----------------------------------------
  logic oben_m_reg;
  logic oben_s_reg;

  always_ff @(negedge link_clk) begin
    oben_m_reg <= output_b_en;
    oben_s_reg <= oben_m_reg;
  end

  // ----------------------------------------
  // read-back framing on output A
  // ----------------------------------------
  logic [19:0] frame_reg;
  logic [4:0] out_cnt_reg;
  logic rb_act_reg;
  logic out_a_reg;
  logic out_b_reg;

  always_ff @(negedge link_clk) begin
    if (lrst_reg) begin
      frame_reg <= 20'h00000;
      out_cnt_reg <= 5'h00;
      rb_act_reg <= 1'b0;
      busy_tgl_reg <= 1'b0;
      out_a_reg <= 1'b0;
      out_b_reg <= 1'b0;
    end else begin
      out_b_reg <= oben_s_reg & result_b; // RL4
      if (read_strobe && arm_s_reg && !rb_act_reg &&
          !qbusy_s_reg) begin // RL10
        rb_act_reg <= 1'b1;
        busy_tgl_reg <= ~busy_tgl_reg;
        out_cnt_reg <= 5'h00;
        if (chinfo_s_reg) begin
          frame_reg <= {rd_val_reg, 4'h0}; // RL2 RL18
        end else begin
          frame_reg <= {1'b0, chan_s_reg, rd_val_reg, 2'h0}; // RL3
        end
      end else if (rb_act_reg) begin
        out_a_reg <= frame_reg[19];
        frame_reg <= {frame_reg[18:0], 1'b0};
        out_cnt_reg <= out_cnt_reg + 5'h01;
        if (out_cnt_reg == 5'(`ADCSRA_FRAME_BITS - 1)) begin
          rb_act_reg <= 1'b0;
          busy_tgl_reg <= ~busy_tgl_reg;
        end
      end else begin
        out_a_reg <= result_a; // RL19
      end
    end
  end

  // ----------------------------------------
  // decoded controls
  // ----------------------------------------
  logic [15:0] seq_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      seq_q <= 16'h0000;
    end else begin
      seq_q <= sequence_queue_setup_reg;
    end
  end

  always_ff @(negedge link_clk) begin
    output_a <= out_a_reg;
    output_b <= out_b_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chan_sel <= 2'h0;
      pseudo_diff_en <= 1'b0;
      power_sel <= 2'h0;
      queue_en <= 1'b0;
      depth_sel <= 2'h0;
      special_read_en <= 1'b0;
      full_clock_en <= 1'b0;
      chan_info_off <= 1'b0;
      count_en <= 1'b0;
      soft_reset <= 1'b0;
      ref_power_off_one <= 1'b1;
      ref_power_off_two <= 1'b1;
      level_one <= 10'h3FF;
      level_two <= 10'h3FF;
      seq_setup <= 16'h0000;
      cm_setup <= 16'h0000;
    end else begin
      pseudo_diff_en <= setup_word_reg[`ADCSRA_F_PSEUDO]; // RL17
      chan_sel <= setup_word_reg[`ADCSRA_F_PSEUDO] ?
                  setup_word_reg[15:14] :
                  {setup_word_reg[15], 1'b0}; // RL12
      power_sel <= setup_word_reg[11:10]; // RL14
      queue_en <= setup_word_reg[`ADCSRA_F_QUEUE]; // RL15
      depth_sel <= setup_word_reg[`ADCSRA_F_QUEUE] ? seq_q[1:0] : 2'h0;
      special_read_en <= setup_word_reg[`ADCSRA_F_SPECIAL]; // RL16
      full_clock_en <= setup_word_reg[`ADCSRA_F_FULLCLK]; // RL9
      chan_info_off <= setup_word_reg[`ADCSRA_F_CHINFO_OFF]; // RL18
      count_en <= setup_word_reg[`ADCSRA_F_COUNT] &
                  ~setup_word_reg[`ADCSRA_F_CHINFO_OFF]; // RL19
      soft_reset <= soft_reset_reg;
      ref_power_off_one <= reference_level_one_reg[`ADCSRA_F_REF_OFF]; // RL22
      ref_power_off_two <= reference_level_two_reg[`ADCSRA_F_REF_OFF];
      level_one <= reference_level_one_reg[9:0];
      level_two <= reference_level_two_reg[9:0];
      seq_setup <= sequence_queue_setup_reg;
      cm_setup <= reference_common_select_reg;
    end
  end

endmodule
`default_nettype wire

// *** dv/adcsra_monitor.sv ***
// assertions on the ports of the serial register access block
`timescale 1ns/1ps
`default_nettype none
module adcsra_monitor #(
  parameter int WORD_BITS = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic read_strobe,
  input wire logic result_a,
  input wire logic output_b_en,
  input wire logic output_a,
  input wire logic output_b,
  input wire logic [1:0] chan_sel,
  input wire logic pseudo_diff_en,
  input wire logic [1:0] power_sel,
  input wire logic special_read_en,
  input wire logic full_clock_en,
  input wire logic soft_reset,
  input wire logic ref_power_off_one,
  input wire logic ref_power_off_two,
  input wire logic [9:0] level_one,
  input wire logic [9:0] level_two,
  input wire logic [15:0] seq_setup,
  input wire logic [15:0] cm_setup
);
  // link edges since the last strobe or reset
  logic [5:0] since_reg;
  always_ff @(negedge link_clk) begin
    if (rst || read_strobe) begin
      since_reg <= 6'h00;
    end else if (since_reg != 6'h3F) begin
      since_reg <= since_reg + 6'h01;
    end
  end
  sequence defaults_s;
    level_one == 10'h3FF && level_two == 10'h3FF && ref_power_off_one
      && ref_power_off_two && power_sel == 2'h0 && chan_sel == 2'h0;
  endsequence
  soft_pulse_a: assert property (@(posedge clk) disable iff (rst)
    soft_reset |=> !soft_reset) else $error("soft reset pulse too long");
  soft_restore_a: assert property (@(posedge clk) disable iff (rst)
    soft_reset |-> ##[0:4] defaults_s) else $error("soft reset not restored");
  reset_levels_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> defaults_s) else $error("bad level after reset");
  reset_modes_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> !special_read_en && !full_clock_en && !pseudo_diff_en)
    else $error("bad modes after reset");
  setting_time_a: assert property (@(negedge link_clk) disable iff (rst)
    $changed({power_sel, level_one, level_two}) |-> since_reg inside {[15:40]})
    else $error("setting changed at wrong time");
  table_time_a: assert property (@(negedge link_clk) disable iff (rst)
    $changed({seq_setup, cm_setup}) |-> since_reg inside {[15:40]})
    else $error("table changed at wrong time");
  idle_pass_a: assert property (@(negedge link_clk) disable iff (rst)
    since_reg > 6'd30 |-> output_a == $past(result_a, 2))
    else $error("output a not passing result");
  outb_gate_a: assert property (@(negedge link_clk) disable iff (rst)
    !$past(output_b_en, 4) |-> !output_b) else $error("output b not gated");
endmodule
`default_nettype wire

// *** dv/adcsra_host_model.sv ***
// host model driving strobe and serial word
`timescale 1ns/1ps
`default_nettype none
module adcsra_host_model (
  input wire logic link_clk,
  input wire logic output_a,
  output var logic read_strobe,
  output var logic serial_in
);
  initial begin
    read_strobe = 1'b0;
    serial_in = 1'b1;
  end
  // one access of forty edges, read-back bits captured
  task automatic xfer(input logic [15:0] w, output logic [19:0] f);
    for (int j = 0; j < 40; j++) begin
      @(posedge link_clk);
      if (j >= 3 && j <= 22) f[22 - j] = output_a;
      read_strobe <= (j == 0);
      if (j < 16) serial_in <= w[15 - j];
      else serial_in <= ~serial_in;
    end
  endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// testbench for the serial register access block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic result_a = 1'b0;
  logic result_b = 1'b0;
  logic output_b_en = 1'b1;
  logic queue_busy = 1'b0;
  logic read_strobe, serial_in, output_a, output_b, pseudo_diff_en;
  logic queue_en, special_read_en, full_clock_en, chan_info_off, count_en;
  logic soft_reset, ref_power_off_one, ref_power_off_two;
  logic [1:0] chan_sel, power_sel, depth_sel;
  logic [9:0] level_one, level_two;
  logic [15:0] seq_setup, cm_setup, w;
  logic [19:0] frame;
  logic [3:0] acc [4] = '{4'h0, 4'h8, 4'h7, 4'hF};
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  initial forever #20 clk = ~clk;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end
  adcsra_top dut (.clk(clk), .rst(rst), .link_clk(link_clk),
    .read_strobe(read_strobe), .serial_in(serial_in),
    .queue_busy(queue_busy),
    .result_a(result_a), .result_b(result_b), .output_b_en(output_b_en),
    .output_a(output_a), .output_b(output_b), .chan_sel(chan_sel),
    .pseudo_diff_en(pseudo_diff_en), .power_sel(power_sel),
    .queue_en(queue_en), .depth_sel(depth_sel),
    .special_read_en(special_read_en), .full_clock_en(full_clock_en),
    .chan_info_off(chan_info_off), .count_en(count_en),
    .soft_reset(soft_reset), .ref_power_off_one(ref_power_off_one),
    .ref_power_off_two(ref_power_off_two), .level_one(level_one),
    .level_two(level_two), .seq_setup(seq_setup), .cm_setup(cm_setup));
  adcsra_host_model host (.link_clk(link_clk), .output_a(output_a),
    .read_strobe(read_strobe), .serial_in(serial_in));
  function automatic logic [9:0] cfg();
    return {chan_sel, power_sel, queue_en, special_read_en, full_clock_en,
      pseudo_diff_en, chan_info_off, count_en};
  endfunction
  function automatic logic [9:0] exp_cfg(input logic [15:0] v);
    return {v[6] ? v[15:14] : {v[15], 1'b0}, v[11:6], v[5],
      v[4] & ~v[5]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(negedge clk) begin
    result_a <= ~result_a;
    result_b <= cycles[1];
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(posedge link_clk);
    chk(cfg(), 12'h000);
    chk({ref_power_off_one, level_one, ref_power_off_two, level_two},
      22'h3FFFFF);
    for (int p = 0; p < 4; p++) begin
      w = {p[1:0], 2'b01, p[1:0], p[0], p[1], p[0], p[1], ~p[0], p[0], acc[p]};
      host.xfer(w, frame);
      chk(cfg(), exp_cfg(w));
    end
    host.xfer(16'hC000, frame);
    chk(cfg(), exp_cfg(w));
    host.xfer(16'h1022, frame);
    host.xfer(16'hF955, frame);
    host.xfer(16'h102D, frame);
    host.xfer(16'h07AA, frame);
    chk({ref_power_off_one, level_one, ref_power_off_two, level_two},
      {1'b0, 10'h155, 1'b1, 10'h3AA});
    host.xfer(16'h1023, frame);
    host.xfer(16'h1C20, frame);
    chk(frame, 20'h01550);
    chk(power_sel, 2'h0);
    host.xfer(16'h1021, frame);
    @(negedge clk) queue_busy = 1'b1;
    repeat (3) @(negedge link_clk);
    host.xfer(16'h0000, frame);
    @(negedge clk) queue_busy = 1'b0;
    repeat (3) @(negedge link_clk);
    host.xfer(16'h0000, frame);
    chk(frame, 20'h10210);
    host.xfer(16'h1029, frame);
    host.xfer(16'h1236, frame);
    host.xfer(16'h122C, frame);
    host.xfer(16'hABCD, frame);
    chk({seq_setup, cm_setup}, 32'h1236ABCD);
    chk(depth_sel, 2'h2);
    host.xfer(16'h900B, frame);
    @(negedge clk) output_b_en = 1'b0;
    host.xfer(16'h0000, frame);
    @(negedge clk) output_b_en = 1'b1;
    chk(frame, 20'h448D8);
    host.xfer(16'h1024, frame);
    chk({ref_power_off_one, level_one, ref_power_off_two, level_two},
      22'h3FFFFF);
    chk({seq_setup, cm_setup}, 32'h0);
    end_sim();
  end
endmodule
bind adcsra_top adcsra_monitor #(.WORD_BITS(WORD_BITS)) mon (.clk(clk),
  .rst(rst), .link_clk(link_clk), .read_strobe(read_strobe),
  .result_a(result_a), .output_b_en(output_b_en), .output_a(output_a),
  .output_b(output_b), .chan_sel(chan_sel), .pseudo_diff_en(pseudo_diff_en),
  .power_sel(power_sel), .special_read_en(special_read_en),
  .full_clock_en(full_clock_en), .soft_reset(soft_reset),
  .ref_power_off_one(ref_power_off_one),
  .ref_power_off_two(ref_power_off_two), .level_one(level_one),
  .level_two(level_two), .seq_setup(seq_setup), .cm_setup(cm_setup));
`default_nettype wire
